// ### design/epc_pkg.sv
package epc_pkg;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [4:0] EPC_ADDR_CTRL1 = 5'h17;
	localparam logic [4:0] EPC_ADDR_CTRL2 = 5'h18;

	// ****************************************
	// field positions, first register
	// ****************************************
	localparam int EPC_C1_RSV_HI = 15;
	localparam int EPC_C1_RSV_LO = 14;
	localparam int EPC_C1_MODE_HI = 13;
	localparam int EPC_C1_MODE_LO = 8;
	localparam int EPC_MODE_MACIF = 4;
	localparam int EPC_MODE_PREF = 3;
	localparam int EPC_MODE_MEDIA_HI = 2;
	localparam int EPC_MODE_MEDIA_LO = 0;
	localparam int EPC_C1_OVR_HI = 7;
	localparam int EPC_C1_OVR_LO = 6;
	localparam int EPC_C1_FELB = 3;

	// ****************************************
	// field positions, second register
	// ****************************************
	localparam int EPC_C2_EDGE_HI = 15;
	localparam int EPC_C2_EDGE_LO = 13;
	localparam int EPC_C2_RPM = 12;
	localparam int EPC_C2_JUMBO_HI = 5;
	localparam int EPC_C2_JUMBO_LO = 4;
	localparam int EPC_C2_CLB = 0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [5:0] EPC_RST_MODE = 6'h00;
	localparam logic [1:0] EPC_RST_C1_RSV = 2'h0;
	localparam logic [1:0] EPC_RST_OVR = 2'h0;
	localparam logic EPC_RST_FELB = 1'b0;
	localparam logic [2:0] EPC_RST_EDGE = 3'h0;
	localparam logic EPC_RST_RPM = 1'b0;
	localparam logic [1:0] EPC_RST_JUMBO = 2'h0;
	localparam logic EPC_RST_CLB = 1'b0;

	// ****************************************
	// encodings
	// ****************************************
	typedef enum logic [2:0] {
		EPC_MEDIA_COPPER = 3'h0,
		EPC_MEDIA_SERDES = 3'h1,
		EPC_MEDIA_FIB1000 = 3'h2,
		EPC_MEDIA_FX100 = 3'h3,
		EPC_MEDIA_RSVD = 3'h4,
		EPC_MEDIA_AMS_SERDES = 3'h5,
		EPC_MEDIA_AMS_FIB1000 = 3'h6,
		EPC_MEDIA_AMS_FX100 = 3'h7
	} epc_media_t;

	localparam logic [1:0] EPC_OVR_NORMAL = 2'h0;
	localparam logic [1:0] EPC_OVR_SERDES = 2'h1;
	localparam logic [1:0] EPC_OVR_COPPER = 2'h2;
	localparam logic [1:0] EPC_MACIF_GLOBAL_OK = 2'h0;

	localparam logic [1:0] EPC_JUMBO_NORMAL = 2'h0;
	localparam logic [1:0] EPC_JUMBO_9K = 2'h1;
	localparam logic [1:0] EPC_JUMBO_12K = 2'h2;
	// packet lengths in half-kilobyte units
	localparam logic [5:0] EPC_LEN_1K5 = 6'h03;
	localparam logic [5:0] EPC_LEN_9K = 6'h12;
	localparam logic [5:0] EPC_LEN_12K = 6'h18;
	localparam logic [5:0] EPC_LEN_16K = 6'h20;
	localparam logic [7:0] EPC_PPM_9K_BOOST = 8'h3C;
	localparam logic [7:0] EPC_PPM_12K_BOOST = 8'h46;

	// ****************************************
	// management frame
	// ****************************************
	localparam logic [5:0] EPC_SMI_PREAMBLE = 6'h20;
	localparam logic [1:0] EPC_SMI_START = 2'h1;
	localparam logic [1:0] EPC_SMI_OP_RD = 2'h2;
	localparam logic [1:0] EPC_SMI_OP_WR = 2'h1;
	localparam logic [3:0] EPC_SMI_HDR_LAST = 4'hD;
	localparam logic [3:0] EPC_SMI_DATA_LAST = 4'hF;

	typedef struct packed {
		logic wr;
		logic [4:0] addr;
		logic [15:0] data;
	} epc_smi_req_t;

endpackage

// ### design/epc_sync2.sv
`timescale 1ns/100ps
module epc_sync2 #(
	parameter int W = 1
) (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);

	// ****************************************
	// two-stage synchroniser
	// ****************************************
	logic [W-1:0] meta;

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta <= '0;
			q_o <= '0;
		end else if (ce_i) begin
			meta <= d_i;
			q_o <= meta;
		end
	end

endmodule

// ### design/epc_smi_slave.sv
`timescale 1ns/100ps
module epc_smi_slave (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic mdc_s_i,
	input wire logic mdio_s_i,
	input wire logic [4:0] phy_addr_i,
	input wire logic [15:0] rd_data_i,
	output epc_pkg::epc_smi_req_t req_o,
	output logic mdio_o,
	output logic mdio_oe_n_o
);

	// ****************************************
	// frame state
	// ****************************************
	typedef enum logic [2:0] {
		EPC_SMI_PRE = 3'b000,
		EPC_SMI_HDR = 3'b001,
		EPC_SMI_TA = 3'b010,
		EPC_SMI_RDATA = 3'b011,
		EPC_SMI_WDATA = 3'b100
	} epc_smi_state_t;

	epc_smi_state_t state;
	logic mdc_d;
	logic [5:0] pre_cnt;
	logic [3:0] bit_cnt;
	logic [13:0] shreg;
	logic [15:0] rd_buf;
	logic is_rd;

	wire mdc_rise = mdc_s_i & ~mdc_d;
	wire [13:0] hdr = {shreg[12:0], mdio_s_i};
	wire hdr_ok = (hdr[13:12] == epc_pkg::EPC_SMI_START) && (hdr[9:5] == phy_addr_i);
	wire hdr_rd = hdr_ok && (hdr[11:10] == epc_pkg::EPC_SMI_OP_RD);
	wire hdr_wr = hdr_ok && (hdr[11:10] == epc_pkg::EPC_SMI_OP_WR);
	wire pre_full = (pre_cnt == epc_pkg::EPC_SMI_PREAMBLE);

	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= EPC_SMI_PRE;
			mdc_d <= 1'b0;
			pre_cnt <= 6'h00;
			bit_cnt <= 4'h0;
			shreg <= 14'h0000;
			rd_buf <= 16'h0000;
			is_rd <= 1'b0;
			req_o <= '0;
			mdio_o <= 1'b0;
			mdio_oe_n_o <= 1'b1;
		end else if (ce_i) begin
			mdc_d <= mdc_s_i;
			req_o.wr <= 1'b0;
			if (mdc_rise) begin
				unique case (state)
					EPC_SMI_PRE: begin
						if (mdio_s_i) begin
							pre_cnt <= pre_full ? pre_cnt : pre_cnt + 6'h01;
						end else if (pre_full) begin
							state <= EPC_SMI_HDR;
							bit_cnt <= 4'h1;
							shreg <= 14'h0000;
						end else begin
							pre_cnt <= 6'h00;
						end
					end
					EPC_SMI_HDR: begin
						shreg <= hdr;
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == epc_pkg::EPC_SMI_HDR_LAST) begin
							bit_cnt <= 4'h0;
							pre_cnt <= 6'h00;
							req_o.addr <= hdr[4:0];
							is_rd <= hdr_rd;
							state <= (hdr_rd || hdr_wr) ? EPC_SMI_TA : EPC_SMI_PRE;
						end
					end
					EPC_SMI_TA: begin
						bit_cnt <= 4'h0;
						if (bit_cnt == 4'h0) begin
							bit_cnt <= 4'h1;
							rd_buf <= rd_data_i;
							mdio_o <= 1'b0;
							mdio_oe_n_o <= ~is_rd;
						end else if (is_rd) begin
							mdio_o <= rd_buf[15];
							rd_buf <= {rd_buf[14:0], 1'b0};
							state <= EPC_SMI_RDATA;
						end else begin
							state <= EPC_SMI_WDATA;
						end
					end
					EPC_SMI_RDATA: begin
						bit_cnt <= bit_cnt + 4'h1;
						mdio_o <= rd_buf[15];
						rd_buf <= {rd_buf[14:0], 1'b0};
						if (bit_cnt == epc_pkg::EPC_SMI_DATA_LAST) begin
							mdio_o <= 1'b0;
							mdio_oe_n_o <= 1'b1;
							state <= EPC_SMI_PRE;
						end
					end
					EPC_SMI_WDATA: begin
						bit_cnt <= bit_cnt + 4'h1;
						req_o.data <= {req_o.data[14:0], mdio_s_i};
						if (bit_cnt == epc_pkg::EPC_SMI_DATA_LAST) begin
							req_o.wr <= 1'b1;
							state <= EPC_SMI_PRE;
						end
					end
					default: begin
						state <= EPC_SMI_PRE;
					end
				endcase
			end
		end
	end

endmodule

// ### design/epc_ext_ctrl.sv
`timescale 1ns/100ps
// Operation
// RULE_01: bit 12 selects SGMII or 1000BASE-X interface
// RULE_02: bit 11 sets copper or SerDes preference
// RULE_03: field 10:8 codes 0-3 select single medium
// RULE_04: codes 5-7 enable automatic media selection
// RULE_05: field 7:6 forces SerDes or copper only
// RULE_06: mode bits 13:8 apply at software reset
// RULE_07: mode bits read back active mode only
// RULE_08: field 15:13 sets 100BASE-TX edge rate
// RULE_09: field 5:4 sets maximum packet length
// RULE_10: better clock offset raises jumbo limits
// RULE_11: super-sticky bits survive every software reset
// RULE_12: sticky bits survive reset only when enabled
// RULE_13: far-end, connector loopback and reduced power
// RULE_14: host avoids reserved codes, writes zero reserved
module epc_ext_ctrl (
	input wire logic core_clk_i,
	input wire logic resetn_i,
	input wire logic ce_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n_o,
	input wire logic [4:0] phy_addr_i,
	input wire logic soft_reset_i,
	input wire logic sticky_reset_en_i,
	input wire logic [1:0] mac_if_global_i,
	input wire logic [7:0] ref_ppm_offset_i,
	output logic mac_if_1000bx_o,
	output logic ams_pref_copper_o,
	output logic [2:0] media_mode_o,
	output logic ams_enable_o,
	output logic copper_allow_o,
	output logic serdes_allow_o,
	output logic [1:0] ams_override_o,
	output logic far_end_lb_o,
	output logic conn_lb_o,
	output logic reduced_power_o,
	output logic [2:0] edge_rate_o,
	output logic signed [3:0] edge_step_o,
	output logic [1:0] jumbo_mode_o,
	output logic [5:0] max_pkt_len_o
);

	// ****************************************
	// pin synchronisers and management slave
	// ****************************************
	logic [6:0] pins_s;
	logic [15:0] rd_data;
	epc_pkg::epc_smi_req_t req;

	epc_sync2 #(
		.W(7)
	) u_sync (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.d_i({phy_addr_i, mdio_i, mdc_i}),
		.q_o(pins_s)
	);

	epc_smi_slave u_smi (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.mdc_s_i(pins_s[0]),
		.mdio_s_i(pins_s[1]),
		.phy_addr_i(pins_s[6:2]),
		.rd_data_i(rd_data),
		.req_o(req),
		.mdio_o(mdio_o),
		.mdio_oe_n_o(mdio_oe_n_o)
	);

	// ****************************************
	// functions
	// ****************************************
	function automatic logic signed [3:0] edge_step(input logic [2:0] code);
		logic signed [3:0] s;
		s = $signed({1'b0, code}) + 4'sh2;
		if (code[2]) begin
			s = $signed({1'b0, code}) - 4'sh6;
		end
		return s;
	endfunction

	function automatic logic [5:0] max_len(input logic [1:0] mode, input logic [7:0] ppm);
		logic [5:0] len;
		len = epc_pkg::EPC_LEN_1K5;
		if (mode == epc_pkg::EPC_JUMBO_9K) begin
			len = (ppm <= epc_pkg::EPC_PPM_9K_BOOST) ? epc_pkg::EPC_LEN_12K : epc_pkg::EPC_LEN_9K;
		end else if (mode == epc_pkg::EPC_JUMBO_12K) begin
			len = (ppm <= epc_pkg::EPC_PPM_12K_BOOST) ? epc_pkg::EPC_LEN_16K
				: epc_pkg::EPC_LEN_12K;
		end
		return len;
	endfunction

	// ****************************************
	// register state
	// ****************************************
	logic [5:0] mode_pend;
	logic [5:0] mode_act;
	logic [1:0] c1_rsv;
	logic [1:0] c1_ovr;
	logic c1_felb;
	logic [2:0] c2_edge;
	logic c2_rpm;
	logic [1:0] c2_jumbo;
	logic c2_clb;

	wire wr1 = req.wr && (req.addr == epc_pkg::EPC_ADDR_CTRL1);
	wire wr2 = req.wr && (req.addr == epc_pkg::EPC_ADDR_CTRL2);
	wire sticky_clr = soft_reset_i && !sticky_reset_en_i;

	// first register: mode group super-sticky, others default on soft reset
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode_pend <= epc_pkg::EPC_RST_MODE;
			mode_act <= epc_pkg::EPC_RST_MODE;
			c1_rsv <= epc_pkg::EPC_RST_C1_RSV;
			c1_ovr <= epc_pkg::EPC_RST_OVR;
			c1_felb <= epc_pkg::EPC_RST_FELB;
		end else if (ce_i) begin
			if (soft_reset_i) begin
				mode_act <= mode_pend; // [RULE_06] [RULE_11]
				c1_rsv <= epc_pkg::EPC_RST_C1_RSV;
				c1_ovr <= epc_pkg::EPC_RST_OVR;
				c1_felb <= epc_pkg::EPC_RST_FELB;
			end
			if (wr1) begin
				mode_pend <= req.data[epc_pkg::EPC_C1_MODE_HI:epc_pkg::EPC_C1_MODE_LO]; // [RULE_06]
				c1_rsv <= req.data[epc_pkg::EPC_C1_RSV_HI:epc_pkg::EPC_C1_RSV_LO];
				c1_ovr <= req.data[epc_pkg::EPC_C1_OVR_HI:epc_pkg::EPC_C1_OVR_LO]; // [RULE_05]
				c1_felb <= req.data[epc_pkg::EPC_C1_FELB]; // [RULE_13]
			end
		end
	end

	// second register: sticky fields, loopback plain
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			c2_edge <= epc_pkg::EPC_RST_EDGE;
			c2_rpm <= epc_pkg::EPC_RST_RPM;
			c2_jumbo <= epc_pkg::EPC_RST_JUMBO;
			c2_clb <= epc_pkg::EPC_RST_CLB;
		end else if (ce_i) begin
			if (sticky_clr) begin
				c2_edge <= epc_pkg::EPC_RST_EDGE; // [RULE_12]
				c2_rpm <= epc_pkg::EPC_RST_RPM;
				c2_jumbo <= epc_pkg::EPC_RST_JUMBO;
			end
			if (soft_reset_i) begin
				c2_clb <= epc_pkg::EPC_RST_CLB;
			end
			if (wr2) begin
				c2_edge <= req.data[epc_pkg::EPC_C2_EDGE_HI:epc_pkg::EPC_C2_EDGE_LO]; // [RULE_08]
				c2_rpm <= req.data[epc_pkg::EPC_C2_RPM]; // [RULE_13]
				c2_jumbo <= req.data[epc_pkg::EPC_C2_JUMBO_HI:epc_pkg::EPC_C2_JUMBO_LO]; // [RULE_09]
				c2_clb <= req.data[epc_pkg::EPC_C2_CLB]; // [RULE_13]
			end
		end
	end

	// ****************************************
	// read data, reserved read-only bits as zero
	// ****************************************
	wire [15:0] rd_c1 = {c1_rsv, mode_act, c1_ovr, 2'h0, c1_felb, 3'h0}; // [RULE_07]
	wire [15:0] rd_c2 = {c2_edge, c2_rpm, 6'h00, c2_jumbo, 3'h0, c2_clb};
	assign rd_data = (req.addr == epc_pkg::EPC_ADDR_CTRL1) ? rd_c1
		: (req.addr == epc_pkg::EPC_ADDR_CTRL2) ? rd_c2 : 16'h0000;

	// ****************************************
	// media decode
	// ****************************************
	wire [2:0] media = mode_act[epc_pkg::EPC_MODE_MEDIA_HI:epc_pkg::EPC_MODE_MEDIA_LO];
	wire next_ams = media[2] && (media[1:0] != 2'h0); // [RULE_04]
	wire mode_copper = (media == epc_pkg::EPC_MEDIA_COPPER) || next_ams; // [RULE_03]
	// reserved media code leaves neither medium enabled
	wire mode_serdes = (!media[2] && (media != epc_pkg::EPC_MEDIA_COPPER)) || next_ams; // [RULE_14]
	wire next_copper = (c1_ovr == epc_pkg::EPC_OVR_COPPER) ? 1'b1
		: (c1_ovr == epc_pkg::EPC_OVR_SERDES) ? 1'b0 : mode_copper; // [RULE_05]
	wire next_serdes = (c1_ovr == epc_pkg::EPC_OVR_SERDES) ? 1'b1
		: (c1_ovr == epc_pkg::EPC_OVR_COPPER) ? 1'b0 : mode_serdes; // [RULE_05]
	wire next_macif = mode_act[epc_pkg::EPC_MODE_MACIF]
		&& (mac_if_global_i == epc_pkg::EPC_MACIF_GLOBAL_OK); // [RULE_01]
	// reserved jumbo code falls back to normal length
	wire [5:0] next_len = max_len(c2_jumbo, ref_ppm_offset_i); // [RULE_10] [RULE_14]

	// ****************************************
	// output flops
	// ****************************************
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mac_if_1000bx_o <= 1'b0;
			ams_pref_copper_o <= 1'b0;
			media_mode_o <= 3'h0;
			ams_enable_o <= 1'b0;
			copper_allow_o <= 1'b0;
			serdes_allow_o <= 1'b0;
			ams_override_o <= 2'h0;
			far_end_lb_o <= 1'b0;
			conn_lb_o <= 1'b0;
			reduced_power_o <= 1'b0;
			edge_rate_o <= 3'h0;
			edge_step_o <= 4'sh0;
			jumbo_mode_o <= 2'h0;
			max_pkt_len_o <= 6'h00;
		end else if (ce_i) begin
			mac_if_1000bx_o <= next_macif; // [RULE_01]
			ams_pref_copper_o <= mode_act[epc_pkg::EPC_MODE_PREF]; // [RULE_02]
			media_mode_o <= media; // [RULE_03]
			ams_enable_o <= next_ams; // [RULE_04]
			copper_allow_o <= next_copper;
			serdes_allow_o <= next_serdes;
			ams_override_o <= c1_ovr;
			far_end_lb_o <= c1_felb; // [RULE_13]
			conn_lb_o <= c2_clb;
			reduced_power_o <= c2_rpm;
			edge_rate_o <= c2_edge;
			edge_step_o <= edge_step(c2_edge); // [RULE_08]
			jumbo_mode_o <= c2_jumbo;
			max_pkt_len_o <= next_len; // [RULE_09]
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	a_macif_select: assert property (ce_i |=> mac_if_1000bx_o == // [RULE_01]
		($past(mode_act[4]) && $past(mac_if_global_i) == 2'h0))
		else $error("interface mode output wrong");
	a_pref_copper: assert property (ce_i |=> ams_pref_copper_o == $past(mode_act[3])) // [RULE_02]
		else $error("preference output wrong");
	a_single_copper: assert property (ce_i && c1_ovr == 2'h0 && media == 3'h0 // [RULE_03]
		|=> copper_allow_o && !serdes_allow_o && !ams_enable_o)
		else $error("copper only mode wrong");
	a_ams_enable: assert property (ce_i && media == 3'h6 |=> ams_enable_o ##0 // [RULE_04]
		(copper_allow_o || $past(c1_ovr) != 2'h0))
		else $error("automatic selection not enabled");
	a_force_copper: assert property (ce_i && c1_ovr == 2'h2 // [RULE_05]
		|=> copper_allow_o && !serdes_allow_o)
		else $error("copper override wrong");
	a_mode_pending: assert property (ce_i && !soft_reset_i |=> $stable(mode_act)) // [RULE_06]
		else $error("mode changed without software reset");
	a_mode_apply: assert property (ce_i && soft_reset_i |=> mode_act == $past(mode_pend)) // [RULE_06]
		else $error("mode not applied at software reset");
	a_read_active: assert property (req.addr == 5'h17 |-> rd_data[13:8] == mode_act) // [RULE_07]
		else $error("read shows pending mode");
	a_edge_fastest: assert property (ce_i && c2_edge == 3'h4 |=> edge_step_o == -4'sd2) // [RULE_08]
		else $error("edge step wrong");
	a_jumbo_9k: assert property (ce_i && c2_jumbo == 2'h1 && ref_ppm_offset_i > 8'h3C // [RULE_09]
		|=> max_pkt_len_o == 6'h12)
		else $error("9k length wrong");
	a_jumbo_boost: assert property (ce_i && c2_jumbo == 2'h2 && ref_ppm_offset_i <= 8'h46 // [RULE_10]
		|=> max_pkt_len_o == 6'h20)
		else $error("12k boosted length wrong");
	a_super_keep: assert property (ce_i && sticky_clr && !wr1 |=> $stable(mode_pend)) // [RULE_11]
		else $error("super-sticky field lost");
	a_sticky_clear: assert property (ce_i && sticky_clr && !wr2 // [RULE_12]
		|=> c2_edge == 3'h0 && c2_jumbo == 2'h0 && !c2_rpm)
		else $error("sticky field not cleared");
	a_sticky_keep: assert property (ce_i && soft_reset_i && sticky_reset_en_i && !wr2 // [RULE_12]
		|=> $stable(c2_edge) && $stable(c2_jumbo) && $stable(c2_rpm))
		else $error("sticky field not kept");
	a_force_serdes: assert property (ce_i && c1_ovr == 2'h1 // [RULE_05]
		|=> serdes_allow_o && !copper_allow_o)
		else $error("serdes override wrong");
	a_single_serdes: assert property (ce_i && c1_ovr == 2'h0 && !media[2] && media != 3'h0 // [RULE_03]
		|=> serdes_allow_o && !copper_allow_o && !ams_enable_o)
		else $error("serdes only mode wrong");
	a_ams_off: assert property (ce_i && !media[2] |=> !ams_enable_o) // [RULE_04]
		else $error("automatic selection on in single mode");
	a_loopback_out: assert property (ce_i |=> far_end_lb_o == $past(c1_felb) // [RULE_13]
		&& conn_lb_o == $past(c2_clb) && reduced_power_o == $past(c2_rpm))
		else $error("loopback or power output wrong");
	a_plain_clear: assert property (ce_i && soft_reset_i && !wr1 // [RULE_13]
		|=> c1_ovr == 2'h0 && !c1_felb)
		else $error("non-sticky field not cleared");
	a_jumbo_normal: assert property (ce_i && c2_jumbo == 2'h0 |=> max_pkt_len_o == 6'h03) // [RULE_09]
		else $error("normal length wrong");
	a_jumbo_raise: assert property (ce_i && c2_jumbo == 2'h1 && ref_ppm_offset_i <= 8'h3C // [RULE_10]
		|=> max_pkt_len_o == 6'h18)
		else $error("9k boosted length wrong");
	a_edge_default: assert property (ce_i && c2_edge == 3'h6 |=> edge_step_o == 4'sd0) // [RULE_08]
		else $error("default edge step wrong");
	a_ce_freeze: assert property (!ce_i |=> $stable(mode_act) && $stable(c2_edge)) // [RULE_06]
		else $error("state moved while clock enable low");

	// ****************************************
	// cover points
	// ****************************************
	c_mode_apply: cover property (ce_i && soft_reset_i && mode_pend != mode_act);
	c_write_ctrl2: cover property (wr2 && ce_i);
	c_read_drive: cover property (!mdio_oe_n_o);
	c_ams_on: cover property (ams_enable_o);
	c_ce_hold: cover property (!ce_i && soft_reset_i);

endmodule

// ### verif/epc_smi_host.sv
`timescale 1ns/100ps
module epc_smi_host (
	input wire logic core_clk_i,
	input wire logic mdio_i,
	output logic mdc_o,
	output logic mdio_o,
	output logic mdio_oe_n_o,
	output logic done_o,
	output logic [15:0] rd_data_o
);
	// ****************************************
	// idle: clock still, line released
	// ****************************************
	initial begin
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_n_o = 1'b1;
		done_o = 1'b0;
		rd_data_o = 16'h0000;
	end

	// ****************************************
	// one management bit, four clocks a phase
	// ****************************************
	task automatic bit_cyc(input logic v, input logic drv, output logic smp);
		@(posedge core_clk_i) #1;
		mdc_o = 1'b0;
		mdio_o = drv ? v : 1'b1;
		mdio_oe_n_o = ~drv;
		repeat (4) @(posedge core_clk_i);
		#1 mdc_o = 1'b1;
		smp = mdio_i;
		repeat (3) @(posedge core_clk_i);
	endtask

	// ****************************************
	// whole frame, own preamble each time
	// ****************************************
	task automatic frame(input logic wr, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd);
		logic [13:0] hdr;
		logic [15:0] rd;
		logic s;
		hdr = {epc_pkg::EPC_SMI_START, wr ? epc_pkg::EPC_SMI_OP_WR : epc_pkg::EPC_SMI_OP_RD, pa, ra};
		for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
		bit_cyc(1'b1, wr, s);
		bit_cyc(1'b0, wr, s);
		for (int i = 15; i >= 0; i--) bit_cyc(wd[i], wr, rd[i]);
		@(posedge core_clk_i) #1;
		mdc_o = 1'b0;
		mdio_o = 1'b1;
		mdio_oe_n_o = 1'b1;
		if (!wr) begin
			rd_data_o = rd;
			done_o = 1'b1;
			@(posedge core_clk_i) #1;
			done_o = 1'b0;
		end
		repeat (6) @(posedge core_clk_i);
		#1;
	endtask
endmodule

// ### verif/epc_ext_ctrl_tb_top.sv
`timescale 1ns/100ps
module epc_ext_ctrl_tb_top;
	logic core_clk_i, resetn_i, soft_reset_i, sticky_reset_en_i, ce_i;
	logic [1:0] mac_if_global_i;
	logic [7:0] ref_ppm_offset_i;
	logic mdc, host_d, host_oe_n, dev_d, dev_oe_n, mdio_w, done;
	logic [15:0] rdata;
	logic mac_bx, pref_cu, ams_en, cu_ok, sd_ok, felb, clb, rpm;
	logic [2:0] media, edge_r;
	logic [1:0] ovr, jumbo;
	logic signed [3:0] step;
	logic [5:0] plen;
	logic [15:0] exp_q[$];
	logic [4:0] pa = 5'h05;
	int err_count = 0;
	int comparisons = 0;
	integer seed = 32'hB84C3DAC;

	// ****************************************
	// clock and shared line with pull-up
	// ****************************************
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	assign mdio_w = !dev_oe_n ? dev_d : (!host_oe_n ? host_d : 1'b1);

	epc_ext_ctrl epc_ext_ctrl_i (
		.core_clk_i(core_clk_i),
		.resetn_i(resetn_i),
		.ce_i(ce_i),
		.mdc_i(mdc),
		.mdio_i(mdio_w),
		.mdio_o(dev_d),
		.mdio_oe_n_o(dev_oe_n),
		.phy_addr_i(pa),
		.soft_reset_i(soft_reset_i),
		.sticky_reset_en_i(sticky_reset_en_i),
		.mac_if_global_i(mac_if_global_i),
		.ref_ppm_offset_i(ref_ppm_offset_i),
		.mac_if_1000bx_o(mac_bx),
		.ams_pref_copper_o(pref_cu),
		.media_mode_o(media),
		.ams_enable_o(ams_en),
		.copper_allow_o(cu_ok),
		.serdes_allow_o(sd_ok),
		.ams_override_o(ovr),
		.far_end_lb_o(felb),
		.conn_lb_o(clb),
		.reduced_power_o(rpm),
		.edge_rate_o(edge_r),
		.edge_step_o(step),
		.jumbo_mode_o(jumbo),
		.max_pkt_len_o(plen)
	);

	epc_smi_host epc_smi_host_i (
		.core_clk_i(core_clk_i),
		.mdio_i(mdio_w),
		.mdc_o(mdc),
		.mdio_o(host_d),
		.mdio_oe_n_o(host_oe_n),
		.done_o(done),
		.rd_data_o(rdata)
	);

	// ****************************************
	// compare, access and reset helpers
	// ****************************************
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		epc_smi_host_i.frame(1'b0, pa, a, 16'h0000);
	endtask

	task automatic wr(input logic [4:0] p, input logic [4:0] a, input logic [15:0] d);
		epc_smi_host_i.frame(1'b1, p, a, d);
	endtask

	task automatic sreset(input logic en);
		@(posedge core_clk_i) #1;
		sticky_reset_en_i = en;
		soft_reset_i = 1'b1;
		@(posedge core_clk_i) #1;
		soft_reset_i = 1'b0;
		repeat (3) @(posedge core_clk_i);
		#1;
	endtask

	task automatic wrap_up;
		$display("comparisons=%0d err_count=%0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// read-back monitor, oldest note first
	// ****************************************
	always @(posedge core_clk_i) begin
		if (done === 1'b1) begin
			if (exp_q.size() == 0) chk(16'hXXXX, rdata);
			else chk(exp_q.pop_front(), rdata);
		end
	end

	initial begin
		#1200000;
		err_count++;
		wrap_up();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		logic [15:0] act, d;
		logic [31:0] r;
		logic [1:0] j;
		logic [3:0] es;
		logic [5:0] len;
		resetn_i = 1'b0;
		ce_i = 1'b1;
		soft_reset_i = 1'b0;
		sticky_reset_en_i = 1'b1;
		mac_if_global_i = 2'h0;
		ref_ppm_offset_i = 8'h64;
		repeat (8) @(posedge core_clk_i);
		#1 resetn_i = 1'b1;
		repeat (4) @(posedge core_clk_i);
		#1;
		chk({9'h000, 1'b1, epc_pkg::EPC_LEN_1K5}, {9'h000, dev_oe_n, plen});
		rd(epc_pkg::EPC_ADDR_CTRL1, 16'h0000);
		rd(epc_pkg::EPC_ADDR_CTRL2, 16'h0000);
		$display("test defaults done");
		act = 16'h0000;
		for (int m = 0; m < 8; m++) begin
			if (m == 4) continue;
			r = $random(seed);
			mac_if_global_i = r[3:2];
			d = {3'h0, r[0], r[1], m[2:0], 8'h00};
			wr(pa, epc_pkg::EPC_ADDR_CTRL1, d);
			rd(epc_pkg::EPC_ADDR_CTRL1, act);
			sreset(1'b1);
			act = d;
			rd(epc_pkg::EPC_ADDR_CTRL1, act);
			chk({8'h00, r[0] && r[3:2] == epc_pkg::EPC_MACIF_GLOBAL_OK, r[1], m[2:0], m > 4,
				m == 0 || m > 4, m != 0}, {8'h00, mac_bx, pref_cu, media, ams_en, cu_ok, sd_ok});
		end
		$display("test media modes done");
		for (int o = 0; o < 3; o++) begin
			d = {act[15:8], o[1:0], 2'h0, o[0], 3'h0};
			wr(pa, epc_pkg::EPC_ADDR_CTRL1, d);
			rd(epc_pkg::EPC_ADDR_CTRL1, d);
			chk({11'h000, o[1:0], o[0], o != 1, o != 2}, {11'h000, ovr, felb, cu_ok, sd_ok});
		end
		sreset(1'b0);
		rd(epc_pkg::EPC_ADDR_CTRL1, {act[15:8], 8'h00});
		$display("test override done");
		for (int e = 0; e < 8; e++) begin
			r = $random(seed);
			j = 2'(e % 3);
			ref_ppm_offset_i = (j == epc_pkg::EPC_JUMBO_9K ? epc_pkg::EPC_PPM_9K_BOOST :
				epc_pkg::EPC_PPM_12K_BOOST) + {7'h00, e[2]};
			len = (j == epc_pkg::EPC_JUMBO_NORMAL) ? epc_pkg::EPC_LEN_1K5 :
				(j == epc_pkg::EPC_JUMBO_9K) ? (e[2] ? epc_pkg::EPC_LEN_9K : epc_pkg::EPC_LEN_12K) :
				(e[2] ? epc_pkg::EPC_LEN_12K : epc_pkg::EPC_LEN_16K);
			es = {e[2], e[2:0]} + 4'h2;
			d = {e[2:0], r[0], 6'h00, j, 3'h0, r[1]};
			wr(pa, epc_pkg::EPC_ADDR_CTRL2, d);
			rd(epc_pkg::EPC_ADDR_CTRL2, d);
			chk({es, r[0], r[1], j, len, 2'h0}, {step, rpm, clb, jumbo, plen, 2'h0});
			chk({13'h0000, e[2:0]}, {13'h0000, edge_r});
		end
		$display("test edge and length done");
		sreset(1'b1);
		rd(epc_pkg::EPC_ADDR_CTRL2, {d[15:1], 1'b0});
		ce_i = 1'b0;
		sreset(1'b0);
		ce_i = 1'b1;
		rd(epc_pkg::EPC_ADDR_CTRL2, {d[15:1], 1'b0});
		sreset(1'b0);
		rd(epc_pkg::EPC_ADDR_CTRL2, 16'h0000);
		rd(epc_pkg::EPC_ADDR_CTRL1, {act[15:8], 8'h00});
		chk({10'h000, epc_pkg::EPC_LEN_1K5}, {10'h000, plen});
		$display("test sticky done");
		wr(pa + 5'h01, epc_pkg::EPC_ADDR_CTRL2, 16'hE011);
		wr(pa, 5'h19, 16'h1234);
		rd(5'h19, 16'h0000);
		rd(epc_pkg::EPC_ADDR_CTRL2, 16'h0000);
		$display("test refused frames done");
		repeat (20) @(posedge core_clk_i);
		wrap_up();
	end
endmodule
